// file: core/dubp_pkg.sv
package dubp_pkg;
  // ---------------------------------------------------------------
  // bus widths and register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_CHAN = 2;
  localparam int unsigned NUM_REGS = 8;
  localparam logic [2:0] REG_RX_TX = 3'h0;
  localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
  localparam int unsigned MCR_IRQ_EN_BIT = 3;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  // status bits that feed the ready pins
  localparam int unsigned ST_TX_READY_BIT = 0;
  localparam int unsigned ST_RX_READY_BIT = 1;
  // host strobe width in clocks
  localparam int unsigned STROBE_NS = 40;
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;

  typedef logic [ADDR_W-1:0] dubp_addr_t;
  typedef logic [DATA_W-1:0] dubp_data_t;
endpackage : dubp_pkg

// file: core/dubp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dubp_if;
  import dubp_pkg::*;
  dubp_addr_t reg_select;
  dubp_data_t host_data_out;
  logic host_data_oe;
  dubp_data_t dev_data_out;
  logic dev_data_oe;
  logic read_strobe_n;
  logic write_strobe_n;
  logic chan0_select_n;
  logic chan1_select_n;
  logic [NUM_CHAN-1:0] irq_out;
  logic [NUM_CHAN-1:0] irq_oe;
  logic [NUM_CHAN-1:0] user_out2_n;
  logic [NUM_CHAN-1:0] tx_ready_n;
  logic [NUM_CHAN-1:0] rx_ready_n;
  modport device (
    input reg_select, host_data_out, host_data_oe, read_strobe_n,
    input write_strobe_n, chan0_select_n, chan1_select_n,
    output dev_data_out, dev_data_oe, irq_out, irq_oe, user_out2_n,
    output tx_ready_n, rx_ready_n
  );
  modport host (
    output reg_select, host_data_out, host_data_oe, read_strobe_n,
    output write_strobe_n, chan0_select_n, chan1_select_n,
    input dev_data_out, dev_data_oe, irq_out, irq_oe, user_out2_n,
    input tx_ready_n, rx_ready_n
  );
endinterface : dubp_if
`default_nettype wire

// file: core/dubp_device.sv
`timescale 1ns/1ps
`default_nettype none
module dubp_device
  import dubp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dubp_if.device bus,
  input wire logic [dubp_pkg::NUM_CHAN-1:0] chan_irq_req,
  input wire logic [dubp_pkg::NUM_CHAN-1:0] chan_tx_space,
  input wire logic [dubp_pkg::NUM_CHAN-1:0] chan_rx_avail,
  input wire dubp_pkg::dubp_data_t chan0_rx_byte,
  input wire dubp_pkg::dubp_data_t chan1_rx_byte,
  output logic [dubp_pkg::NUM_CHAN-1:0] chan_tx_load,
  output logic [dubp_pkg::NUM_CHAN-1:0] chan_rx_take,
  output dubp_pkg::dubp_data_t tx_byte
);
  import dubp_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rd_n_sync_reg;
  logic [1:0] wr_n_sync_reg;
  logic [1:0] cs0_n_sync_reg;
  logic [1:0] cs1_n_sync_reg;
  dubp_addr_t addr_meta_reg;
  dubp_addr_t addr_reg;
  dubp_data_t din_meta_reg;
  dubp_data_t din_reg;
  logic rd_n_prev_reg;
  logic wr_n_prev_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_n_sync_reg <= 2'h3;
      wr_n_sync_reg <= 2'h3;
      cs0_n_sync_reg <= 2'h3;
      cs1_n_sync_reg <= 2'h3;
      addr_meta_reg <= '0;
      addr_reg <= '0;
      din_meta_reg <= '0;
      din_reg <= '0;
      rd_n_prev_reg <= 1'b1;
      wr_n_prev_reg <= 1'b1;
    end
    else
    begin
      rd_n_sync_reg <= {rd_n_sync_reg[0], bus.read_strobe_n};
      wr_n_sync_reg <= {wr_n_sync_reg[0], bus.write_strobe_n};
      cs0_n_sync_reg <= {cs0_n_sync_reg[0], bus.chan0_select_n};
      cs1_n_sync_reg <= {cs1_n_sync_reg[0], bus.chan1_select_n};
      addr_meta_reg <= bus.reg_select;
      addr_reg <= addr_meta_reg;
      din_meta_reg <= bus.host_data_out;
      din_reg <= din_meta_reg;
      rd_n_prev_reg <= rd_n_sync_reg[1];
      wr_n_prev_reg <= wr_n_sync_reg[1];
    end
  end

  // ---------------------------------------------------------------
  // strobe edge helpers
  // ---------------------------------------------------------------
  function automatic logic fell_n(input logic prev_n, input logic now_n);
    return prev_n & ~now_n;
  endfunction : fell_n

  function automatic logic rose_n(input logic prev_n, input logic now_n);
    return ~prev_n & now_n;
  endfunction : rose_n

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire rd_n_s = rd_n_sync_reg[1];
  wire wr_n_s = wr_n_sync_reg[1];
  wire [NUM_CHAN-1:0] sel = {~cs1_n_sync_reg[1], ~cs0_n_sync_reg[1]};
  wire one_sel = sel[0] ^ sel[1];
  wire rd_fall = fell_n(rd_n_prev_reg, rd_n_s);
  wire rd_rise = rose_n(rd_n_prev_reg, rd_n_s);
  wire wr_fall = fell_n(wr_n_prev_reg, wr_n_s);
  wire wr_rise = rose_n(wr_n_prev_reg, wr_n_s);
  wire rd_start = rd_fall && one_sel;
  wire wr_start = wr_fall && one_sel;

  // ---------------------------------------------------------------
  // per-channel register files
  // ---------------------------------------------------------------
  dubp_data_t regs_reg [NUM_CHAN][NUM_REGS];
  dubp_data_t rdata_reg;
  logic rd_active_reg;
  logic wr_active_reg;
  logic [NUM_CHAN-1:0] wr_chan_reg;
  logic [NUM_CHAN-1:0] rd_chan_reg;
  dubp_addr_t wr_addr_reg;
  dubp_addr_t rd_addr_reg;

  function automatic dubp_data_t fetch(input dubp_data_t stored,
                                       input dubp_addr_t a,
                                       input dubp_data_t rxb);
    dubp_data_t v;
    v = stored;
    if (a == REG_RX_TX)
      v = rxb;
    return v;
  endfunction : fetch

  // stored byte is an operand here so the fetch follows every write except to REG_RX_TX, which reads the rx byte
  wire dubp_data_t rd_fetch = sel[1]
    ? fetch(regs_reg[1][addr_reg], addr_reg, chan1_rx_byte)
    : fetch(regs_reg[0][addr_reg], addr_reg, chan0_rx_byte);
  wire wr_to_data = wr_active_reg && wr_addr_reg == REG_RX_TX;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < NUM_CHAN; c++)
        for (int r = 0; r < NUM_REGS; r++)
          regs_reg[c][r] <= REG_RESET_VAL;
      rdata_reg <= '0;
      rd_active_reg <= 1'b0;
      wr_active_reg <= 1'b0;
      wr_chan_reg <= '0;
      rd_chan_reg <= '0;
      wr_addr_reg <= '0;
      rd_addr_reg <= '0;
      tx_byte <= '0;
    end
    else
    begin
      if (rd_start)
      begin
        rdata_reg <= rd_fetch;
        rd_active_reg <= 1'b1;
        rd_chan_reg <= sel;
        rd_addr_reg <= addr_reg;
      end
      else if (rd_n_s || !one_sel)
        rd_active_reg <= 1'b0;
      if (wr_start)
      begin
        wr_active_reg <= 1'b1;
        wr_chan_reg <= sel;
        wr_addr_reg <= addr_reg;
      end
      else if (wr_rise)
      begin
        wr_active_reg <= 1'b0;
        for (int c = 0; c < NUM_CHAN; c++)
          if (wr_active_reg && wr_chan_reg[c])
            regs_reg[c][wr_addr_reg] <= din_reg;
        if (wr_to_data)
          tx_byte <= din_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // channel side strobes
  // ---------------------------------------------------------------
  wire wr_done = wr_rise && wr_to_data;
  wire rd_done = rd_rise && rd_active_reg && rd_addr_reg == REG_RX_TX;
  assign chan_tx_load = wr_done ? wr_chan_reg : '0;
  assign chan_rx_take = rd_done ? rd_chan_reg : '0;

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.dev_data_out = rdata_reg;
  assign bus.dev_data_oe = rd_active_reg & ~rd_n_s & one_sel;


  // ---------------------------------------------------------------
  // interrupt mode and status pins
  // ---------------------------------------------------------------
  wire [NUM_CHAN-1:0] irq_en;

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++)
    begin : g_chan
      assign irq_en[g] = regs_reg[g][REG_MODEM_CTRL][MCR_IRQ_EN_BIT];
    end
  endgenerate

  assign bus.irq_out = chan_irq_req;
  assign bus.irq_oe = irq_en;
  assign bus.user_out2_n = ~irq_en;
  assign bus.tx_ready_n = ~chan_tx_space;
  assign bus.rx_ready_n = ~chan_rx_avail;
endmodule : dubp_device
`default_nettype wire

// file: core/dubp_host.sv
`timescale 1ns/1ps
`default_nettype none
module dubp_host
  import dubp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dubp_if.host bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_chan,
  input wire dubp_pkg::dubp_addr_t req_addr,
  input wire dubp_pkg::dubp_data_t req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output dubp_pkg::dubp_data_t rsp_rdata
);
  import dubp_pkg::*;

  typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} dubp_hstate_t;
  dubp_hstate_t state_reg;
  logic [7:0] cnt_reg;
  logic wr_reg;
  logic chan_reg;
  dubp_addr_t addr_reg;
  dubp_data_t wdata_reg;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  wire cnt_done = cnt_reg == 8'(STROBE_CYC - 1);
  assign req_ready = state_reg == IDLE;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= IDLE;
      cnt_reg <= '0;
      wr_reg <= 1'b0;
      chan_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state_reg)
        IDLE:
          if (req_valid)
          begin
            wr_reg <= req_write;
            chan_reg <= req_chan;
            addr_reg <= req_addr;
            wdata_reg <= req_wdata;
            cnt_reg <= '0;
            state_reg <= SETUP;
          end
        SETUP:
          state_reg <= STROBE;
        STROBE:
          if (cnt_done)
          begin
            state_reg <= HOLD;
            if (!wr_reg)
            begin
              rsp_rdata <= bus.dev_data_out;
              rsp_valid <= 1'b1;
            end
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        HOLD:
        begin
          if (wr_reg)
            rsp_valid <= 1'b1;
          state_reg <= IDLE;
        end
        default:
          state_reg <= IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  wire active = state_reg != IDLE;
  wire strobe = state_reg == STROBE;
  assign bus.reg_select = addr_reg;
  assign bus.chan0_select_n = ~(active & ~chan_reg);
  assign bus.chan1_select_n = ~(active & chan_reg);
  assign bus.read_strobe_n = ~(strobe & ~wr_reg);
  assign bus.write_strobe_n = ~(strobe & wr_reg);
  assign bus.host_data_out = wdata_reg;
  assign bus.host_data_oe = active & wr_reg;
endmodule : dubp_host
`default_nettype wire

// file: dv/dubp_bus_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dubp_bus_sva
  import dubp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire dubp_pkg::dubp_addr_t reg_select,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan0_select_n,
  input wire logic chan1_select_n,
  input wire logic [dubp_pkg::NUM_CHAN-1:0] irq_oe,
  input wire logic [dubp_pkg::NUM_CHAN-1:0] user_out2_n
);
  // ---------------------------------------------------------------
  // bus and pin checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_dev_oe_gated: assert property (
    dev_data_oe |-> $past(!read_strobe_n, 2)
      && $past(chan0_select_n != chan1_select_n, 2))
    else $error("device drives data outside a selected read");
  a_no_wr_drive: assert property (
    !write_strobe_n |-> !dev_data_oe)
    else $error("device drives data during a write");
  a_no_rd_host: assert property (
    !read_strobe_n |-> !host_data_oe)
    else $error("host drives data during a read");
  a_irq_a_mode: assert property (
    irq_oe[0] != user_out2_n[0])
    else $error("channel 0 irq drive and out2 disagree");
  a_irq_b_mode: assert property (
    irq_oe[1] != user_out2_n[1])
    else $error("channel 1 irq drive and out2 disagree");
  a_reset_float: assert property (
    $rose(rst_n) |-> irq_oe == 2'h0 && user_out2_n == 2'h3)
    else $error("irq not floating after reset");
  a_one_select: assert property (
    !(!chan0_select_n && !chan1_select_n))
    else $error("both channel selects low");
  a_addr_steady: assert property (
    $past(!read_strobe_n || !write_strobe_n)
      && (!read_strobe_n || !write_strobe_n) |-> $stable(reg_select))
    else $error("register select moved during a strobe");
  a_wr_data_held: assert property (
    $rose(write_strobe_n) |-> $past(host_data_oe))
    else $error("write data not driven at strobe rise");
endmodule : dubp_bus_sva
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  import dubp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_chan = 1'b0, req_ready;
  logic rsp_valid;
  dubp_addr_t req_addr = 3'h0;
  dubp_data_t req_wdata = 8'h00, rsp_rdata, tx_byte, q;
  logic [1:0] irq_req = 2'h3, tx_space = 2'h0, rx_avail = 2'h0;
  logic [1:0] tx_load, rx_take;
  int bad_count = 0;
  int comparisons = 0;
  int tx_loads = 0;
  int rx_takes = 0;
  dubp_if bus_if ();
  dubp_device dubp_device_i (.clk(clk), .rst_n(rst_n), .bus(bus_if.device),
    .chan_irq_req(irq_req), .chan_tx_space(tx_space),
    .chan_rx_avail(rx_avail), .chan0_rx_byte(8'h5a), .chan1_rx_byte(8'ha5),
    .chan_tx_load(tx_load), .chan_rx_take(rx_take), .tx_byte(tx_byte));
  dubp_host dubp_host_i (.clk(clk), .rst_n(rst_n), .bus(bus_if.host),
    .req_valid(req_valid), .req_write(req_write), .req_chan(req_chan),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  dubp_bus_sva dubp_bus_sva_i (.clk(clk), .rst_n(rst_n),
    .reg_select(bus_if.reg_select), .host_data_oe(bus_if.host_data_oe),
    .dev_data_oe(bus_if.dev_data_oe), .read_strobe_n(bus_if.read_strobe_n),
    .write_strobe_n(bus_if.write_strobe_n),
    .chan0_select_n(bus_if.chan0_select_n),
    .chan1_select_n(bus_if.chan1_select_n), .irq_oe(bus_if.irq_oe),
    .user_out2_n(bus_if.user_out2_n));
  always #4 clk = ~clk;
  // channel 0 pulses weigh 1, channel 1 pulses weigh 16
  always @(posedge clk)
  begin
    tx_loads <= tx_loads + (tx_load[0] ? 1 : 0) + (tx_load[1] ? 16 : 0);
    rx_takes <= rx_takes + (rx_take[0] ? 1 : 0) + (rx_take[1] ? 16 : 0);
  end
  // ---------------------------------------------------------------
  // host request tasks
  // ---------------------------------------------------------------
  task automatic xfer(input logic wr, input logic ch, input dubp_addr_t a,
                      input dubp_data_t d, output dubp_data_t r);
    int n;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = wr;
    req_chan = ch;
    req_addr = a;
    req_wdata = d;
    for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(posedge clk) #1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) @(posedge clk) #1;
    `CHK("rsp_valid", 1'b1, rsp_valid)
    r = rsp_rdata;
  endtask : xfer
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    `CHK("irq_oe", 2'h0, bus_if.irq_oe)
    `CHK("out2_n", 2'h3, bus_if.user_out2_n)
    for (int i = 0; i < 4; i++)
    begin
      tx_space = i[1:0];
      rx_avail = ~i[1:0];
      @(posedge clk) #1;
      `CHK("tx_ready_n", ~i[1:0], bus_if.tx_ready_n)
      `CHK("rx_ready_n", i[1:0], bus_if.rx_ready_n)
    end
    for (int c = 0; c < 2; c++)
      for (int a = 1; a < 8; a++)
        xfer(1'b1, c[0], a[2:0], {a[3:0], 3'h0, c[0]}, q);
    for (int c = 0; c < 2; c++)
      for (int a = 1; a < 8; a++)
      begin
        xfer(1'b0, c[0], a[2:0], 8'h00, q);
        `CHK("reg_rd", {a[3:0], 3'h0, c[0]}, q)
      end
    xfer(1'b0, 1'b0, REG_RX_TX, 8'h00, q);
    `CHK("rx_byte0", 8'h5a, q)
    xfer(1'b0, 1'b1, REG_RX_TX, 8'h00, q);
    `CHK("rx_byte1", 8'ha5, q)
    xfer(1'b1, 1'b1, REG_RX_TX, 8'h3c, q);
    settle();
    `CHK("tx_byte", 8'h3c, tx_byte)
    `CHK("dev_oe", 1'b0, bus_if.dev_data_oe)
    for (int c = 0; c < 2; c++)
    begin
      xfer(1'b1, c[0], REG_MODEM_CTRL, 8'h08, q);
      settle();
      `CHK("irq_oe_on", 1'b1, bus_if.irq_oe[c])
      `CHK("out2_on", 1'b0, bus_if.user_out2_n[c])
      `CHK("irq_level", 1'b1, bus_if.irq_out[c])
      irq_req[c] = 1'b0;
      @(posedge clk) #1;
      `CHK("irq_follow", 1'b0, bus_if.irq_out[c])
      irq_req[c] = 1'b1;
      `CHK("irq_other", 1'b0, bus_if.irq_oe[1-c])
      xfer(1'b1, c[0], REG_MODEM_CTRL, 8'h00, q);
      settle();
      `CHK("irq_oe_off", 1'b0, bus_if.irq_oe[c])
      `CHK("out2_off", 1'b1, bus_if.user_out2_n[c])
    end
    `CHK("tx_byte_kept", 8'h3c, tx_byte)
    xfer(1'b1, 1'b0, REG_MODEM_CTRL, 8'h08, q);
    settle();
    rst_n = 1'b0;
    repeat (2) @(posedge clk) #1;
    rst_n = 1'b1;
    `CHK("irq_oe_rst", 2'h0, bus_if.irq_oe)
    `CHK("out2_rst", 2'h3, bus_if.user_out2_n)
    xfer(1'b0, 1'b0, REG_MODEM_CTRL, 8'h00, q);
    `CHK("mcr_rst", 8'h00, q)
    `CHK("tx_loads", 16, tx_loads)
    `CHK("rx_takes", 17, rx_takes)
    stop_test();
  end
  initial
  begin
    #(4000 * 8);
    bad_count++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
